/* File: design/ptio_scaler.sv */
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module ptio_scaler
  import ptio_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = GATE_CYC,
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        pulse_train_in_pin,
  input  wire logic        encoder_feedback,
  input  wire logic [7:0]  di_in,
  input  wire logic [15:0] freq_cmd_pct,
  input  wire logic [15:0] out_freq_pct,
  input  wire logic [15:0] sfs_freq_pct,
  input  wire logic [15:0] motor_speed_pct,
  input  wire logic [15:0] pid_fb_quant_pct,
  input  wire logic [15:0] pid_in_pct,
  input  wire logic [15:0] out_freq_hz,
  output logic      [15:0] freq_ref_pct,
  output logic             freq_ref_valid,
  output logic      [15:0] pid_fb_pct,
  output logic             pid_fb_valid,
  output logic      [15:0] pid_tgt_pct,
  output logic             pid_tgt_valid,
  output logic             pulse_setting_fault,
  output logic             pulse_train_out_pin,
  output logic             irq
);

  // Input path: proportion by full scale, then gain, then bias, saturated 0..65535.
  function automatic logic [15:0] calc_ref(input logic [15:0] meas, input logic [15:0] scale,
                                           input logic [15:0] gain, input logic [15:0] bias);
    logic [47:0] prop;
    logic [47:0] gained;
    logic signed [49:0] biased;
    prop   = (48'(meas) * 48'(PCT_FULL)) / 48'(scale);
    gained = (prop * 48'(gain)) / 48'h3E8;
    biased = $signed({2'b00, gained}) + 50'($signed(bias)) * 50'shA;
    if (biased < 50'sh0)
      calc_ref = 16'h0000;
    else if (biased > 50'shFFFF)
      calc_ref = 16'hFFFF;
    else
      calc_ref = biased[15:0];
  endfunction : calc_ref

  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < 32'(lo)) ? lo : ((v > 32'(hi)) ? hi : v[15:0]);
  endfunction : clamp16

  ptio_cfg_t   cfg_r;
  ptio_sync_t  sync_r;
  logic [15:0] pin_scale_r;
  logic [15:0] pin_gain_r;
  logic [15:0] pin_bias_r;
  logic [7:0]  pin_filt_r;
  logic [15:0] pout_scale_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_en_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] rd_mux;
  logic        acc_take;

  logic        pin_s1_r, pin_s2_r, pin_s3_r;
  logic        enc_s1_r, enc_s2_r;
  logic [7:0]  di_s1_r, di_s2_r;
  logic [31:0] gate_cnt_r;
  logic [31:0] tick_cnt_r;
  logic [15:0] edge_cnt_r;
  logic [15:0] meas_r;
  logic        meas_done_r;
  logic [15:0] target_r;
  logic [23:0] filt_r;
  logic signed [24:0] filt_step;
  logic        fault_cond;
  logic        fault_d_r;
  logic [1:0]  irq_ev;
  logic [1:0]  irq_clr;
  logic        sync_used;
  logic        sync_act;
  logic [15:0] src_pct;
  logic [15:0] out_hz;
  logic [26:0] nco_r;
  logic [27:0] nco_sum;

  assign acc_take   = hsel && hready && htrans[1];
  assign fault_cond = (cfg_r.pin_func == PIN_FUNC_FB) && (cfg_r.pid_fb_src != PID_FB_PULSE);
  assign sync_used  = (sync_r.code == SYNC_CODE);
  assign sync_act   = di_s2_r[sync_r.term];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= acc_take && hwrite && (hsize == 3'h2);
      wr_addr_r <= haddr[7:0];
      if (acc_take && !hwrite)
        hrdata <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      OFS_CFG:        rd_mux = {21'h000000, cfg_r};
      OFS_SYNC:       rd_mux = {23'h000000, sync_r};
      OFS_PIN_SCALE:  rd_mux = {16'h0000, pin_scale_r};
      OFS_PIN_GAIN:   rd_mux = {16'h0000, pin_gain_r};
      OFS_PIN_BIAS:   rd_mux = {{16{pin_bias_r[15]}}, pin_bias_r};
      OFS_PIN_FILT:   rd_mux = {24'h000000, pin_filt_r};
      OFS_POUT_SCALE: rd_mux = {16'h0000, pout_scale_r};
      OFS_MEAS:       rd_mux = {16'h0000, meas_r};
      OFS_REF:        rd_mux = {16'h0000, filt_r[23:8]};
      OFS_IRQ_STAT:   rd_mux = {30'h00000000, irq_stat_r};
      OFS_IRQ_EN:     rd_mux = {30'h00000000, irq_en_r};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  // Scale, gain, bias and filter settings are clamped on write so the datapath never sees an illegal range; cfg and sync are stored as written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r        <= '0;
      sync_r       <= '0;
      pin_scale_r  <= PIN_SCALE_RST;
      pin_gain_r   <= PIN_GAIN_RST;
      pin_bias_r   <= 16'h0000;
      pin_filt_r   <= 8'h00;
      pout_scale_r <= POUT_SCALE_RST;
      irq_en_r     <= 2'h0;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        OFS_CFG:        cfg_r <= hwdata[10:0];
        OFS_SYNC:       sync_r <= hwdata[8:0];
        OFS_PIN_SCALE:  pin_scale_r <= clamp16(hwdata, SCALE_MIN, SCALE_MAX);
        OFS_PIN_GAIN:   pin_gain_r <= clamp16(hwdata, 16'h0000, GAIN_MAX);
        OFS_PIN_BIAS: begin
          if ($signed(hwdata) > $signed({16'h0000, BIAS_LIM}))
            pin_bias_r <= BIAS_LIM;
          else if ($signed(hwdata) < -$signed({16'h0000, BIAS_LIM}))
            pin_bias_r <= 16'h0000 - BIAS_LIM;
          else
            pin_bias_r <= hwdata[15:0];
        end
        OFS_PIN_FILT:   pin_filt_r <= (hwdata > 32'(FILT_MAX)) ? FILT_MAX : hwdata[7:0];
        OFS_POUT_SCALE: pout_scale_r <= clamp16(hwdata, 16'h0000, SCALE_MAX);
        OFS_IRQ_EN:     irq_en_r <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // A new event wins over a clear written in the same cycle.
  always_comb begin
    irq_ev            = 2'h0;
    irq_ev[IRQ_FAULT] = ce && fault_cond && !fault_d_r;
    irq_ev[IRQ_MEAS]  = ce && meas_done_r;
    irq_clr           = (wr_pend_r && (wr_addr_r == OFS_IRQ_CLR)) ? hwdata[1:0] : 2'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= 2'h0;
      irq        <= 1'b0;
      fault_d_r  <= 1'b0;
    end else begin
      if (ce)
        fault_d_r <= fault_cond;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq        <= |(irq_stat_r & irq_en_r);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      enc_s1_r <= 1'b0;
      enc_s2_r <= 1'b0;
      di_s1_r  <= 8'h00;
      di_s2_r  <= 8'h00;
    end else if (ce) begin
      pin_s1_r <= pulse_train_in_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      enc_s1_r <= encoder_feedback;
      enc_s2_r <= enc_s1_r;
      di_s1_r  <= di_in;
      di_s2_r  <= di_s1_r;
    end
  end

  // A one-second gate makes the edge count the frequency in hertz directly.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_cnt_r  <= 32'h00000000;
      edge_cnt_r  <= 16'h0000;
      meas_r      <= 16'h0000;
      meas_done_r <= 1'b0;
      target_r    <= 16'h0000;
    end else if (ce) begin
      meas_done_r <= 1'b0;
      if (gate_cnt_r == GATE_CYCLES - 1) begin
        gate_cnt_r  <= 32'h00000000;
        meas_r      <= edge_cnt_r;
        edge_cnt_r  <= {15'h0000, pin_s2_r && !pin_s3_r};
        meas_done_r <= 1'b1;
        target_r    <= calc_ref(edge_cnt_r, pin_scale_r, pin_gain_r, pin_bias_r);
      end else begin
        gate_cnt_r <= gate_cnt_r + 32'h00000001;
        if (pin_s2_r && !pin_s3_r && (edge_cnt_r != 16'hFFFF))
          edge_cnt_r <= edge_cnt_r + 16'h0001;
      end
    end
  end

  // First-order filter stepping every 10 ms; eight fraction bits keep small steps alive.
  assign filt_step = ($signed({1'b0, target_r, 8'h00}) - $signed({1'b0, filt_r}))
                     / $signed({16'h0000, 1'b0, pin_filt_r} + 25'sh1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= 32'h00000000;
      filt_r     <= 24'h000000;
    end else if (ce) begin
      if (tick_cnt_r == TICK_CYCLES - 1) begin
        tick_cnt_r <= 32'h00000000;
        filt_r     <= filt_r + filt_step[23:0];
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h00000001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_ref_pct        <= 16'h0000;
      freq_ref_valid      <= 1'b0;
      pid_fb_pct          <= 16'h0000;
      pid_fb_valid        <= 1'b0;
      pid_tgt_pct         <= 16'h0000;
      pid_tgt_valid       <= 1'b0;
      pulse_setting_fault <= 1'b0;
    end else if (ce) begin
      freq_ref_valid <= (cfg_r.ref_src == REF_SRC_PULSE) &&
                        (cfg_r.pin_func == PIN_FUNC_FREQ);
      if (!sync_used || sync_act)
        freq_ref_pct <= filt_r[23:8];
      pid_fb_valid        <= (cfg_r.pin_func == PIN_FUNC_FB);
      pid_fb_pct          <= filt_r[23:8];
      pid_tgt_valid       <= (cfg_r.pin_func == PIN_FUNC_TGT);
      pid_tgt_pct         <= filt_r[23:8];
      pulse_setting_fault <= fault_cond;
    end
  end

  always_comb begin
    case (cfg_r.pout_src)
      POUT_FREQ_CMD: src_pct = freq_cmd_pct;
      POUT_OUT_FREQ: src_pct = out_freq_pct;
      POUT_SFS_FREQ: src_pct = sfs_freq_pct;
      POUT_SPEED:    src_pct = motor_speed_pct;
      POUT_PID_FB:   src_pct = pid_fb_quant_pct;
      POUT_PID_IN:   src_pct = pid_in_pct;
      default:       src_pct = 16'h0000;
    endcase
    if ((cfg_r.pout_src == POUT_OUT_FREQ) && (pout_scale_r == 16'h0000))
      out_hz = out_freq_hz;
    else
      out_hz = 16'((32'(src_pct) * 32'(pout_scale_r)) / 32'(PCT_FULL));
    nco_sum = {1'b0, nco_r} + {11'h000, out_hz, 1'b0};
  end

  // The phase accumulator wraps at the clock rate, toggling twice per output period.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nco_r               <= 27'h0000000;
      pulse_train_out_pin <= 1'b0;
    end else if (ce) begin
      if (cfg_r.pout_src == POUT_ENC_REP) begin
        nco_r               <= 27'h0000000;
        pulse_train_out_pin <= enc_s2_r;
      end else if ((cfg_r.pout_src == 3'h0) || (out_hz == 16'h0000)) begin
        nco_r               <= 27'h0000000;
        pulse_train_out_pin <= 1'b0;
      end else if (nco_sum >= {1'b0, CLK_HZ_W}) begin
        nco_r               <= 27'(nco_sum - {1'b0, CLK_HZ_W});
        pulse_train_out_pin <= !pulse_train_out_pin;
      end else begin
        nco_r <= nco_sum[26:0];
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  fault_flag_a: assert property (ce && fault_cond |=> pulse_setting_fault)
    else $error("setting fault not raised");
  freq_ref_sel_a: assert property (ce && (cfg_r.ref_src != REF_SRC_PULSE)
    |=> !freq_ref_valid)
    else $error("reference valid without pulse source");
  pid_fb_sel_a: assert property (ce && (cfg_r.pin_func != PIN_FUNC_FB) |=> !pid_fb_valid)
    else $error("feedback valid with wrong function");
  pid_tgt_sel_a: assert property (ce && (cfg_r.pin_func == PIN_FUNC_TGT)
    |=> pid_tgt_valid && !pid_fb_valid)
    else $error("target routing wrong");
  enc_repeat_a: assert property (ce && (cfg_r.pout_src == POUT_ENC_REP)
    |=> pulse_train_out_pin == $past(enc_s2_r))
    else $error("encoder pulse not repeated");
  scale_range_a: assert property (pin_scale_r >= SCALE_MIN && pin_scale_r <= SCALE_MAX)
    else $error("input scale out of range");
  bias_range_a: assert property ($signed(pin_bias_r) <= $signed(BIAS_LIM) &&
    $signed(pin_bias_r) >= -$signed(BIAS_LIM) && pin_filt_r <= FILT_MAX)
    else $error("bias or filter out of range");
  pout_off_a: assert property ((ce && cfg_r.pout_src == 3'h0)[*2] |-> !pulse_train_out_pin)
    else $error("pulse output active while off");
  sync_hold_a: assert property (ce && sync_used && !sync_act |=> $stable(freq_ref_pct))
    else $error("reference moved without sync");
  gate_measure_a: assert property (meas_done_r
    |-> gate_cnt_r == 32'h00000000 && !$past(meas_done_r))
    else $error("gate end misaligned");

  fault_seen_c: cover property (ce && fault_cond ##1 pulse_setting_fault);
  enc_rep_c:    cover property (cfg_r.pout_src == POUT_ENC_REP && $rose(pulse_train_out_pin));
  sync_gate_c:  cover property (sync_used && $rose(sync_act));
  meas_edge_c:  cover property (meas_done_r && meas_r != 16'h0000);

endmodule : ptio_scaler

/* File: include/ptio_pkg.sv */
package ptio_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned GATE_TIME_MS  = 1000;
  localparam int unsigned TICK_TIME_MS  = 10;
  localparam int unsigned GATE_CYC      = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam logic [26:0] CLK_HZ_W      = 27'h7735940;

  localparam logic [7:0] OFS_CFG        = 8'h00;
  localparam logic [7:0] OFS_SYNC       = 8'h04;
  localparam logic [7:0] OFS_PIN_SCALE  = 8'h08;
  localparam logic [7:0] OFS_PIN_GAIN   = 8'h0C;
  localparam logic [7:0] OFS_PIN_BIAS   = 8'h10;
  localparam logic [7:0] OFS_PIN_FILT   = 8'h14;
  localparam logic [7:0] OFS_POUT_SCALE = 8'h18;
  localparam logic [7:0] OFS_MEAS       = 8'h1C;
  localparam logic [7:0] OFS_REF        = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR    = 8'h28;
  localparam logic [7:0] OFS_IRQ_EN     = 8'h2C;

  localparam logic [15:0] PIN_SCALE_RST  = 16'h03E8;
  localparam logic [15:0] PIN_GAIN_RST   = 16'h03E8;
  localparam logic [15:0] POUT_SCALE_RST = 16'h03E8;
  localparam logic [15:0] SCALE_MIN      = 16'h0032;
  localparam logic [15:0] SCALE_MAX      = 16'h7D00;
  localparam logic [15:0] GAIN_MAX       = 16'h2710;
  localparam logic [15:0] BIAS_LIM       = 16'h03E8;
  localparam logic [7:0]  FILT_MAX       = 8'hC8;
  localparam logic [15:0] PCT_FULL       = 16'h2710;

  localparam logic [2:0] REF_SRC_PULSE  = 3'h4;
  localparam logic [1:0] PIN_FUNC_FREQ  = 2'h0;
  localparam logic [1:0] PIN_FUNC_FB    = 2'h1;
  localparam logic [1:0] PIN_FUNC_TGT   = 2'h2;
  localparam logic [2:0] PID_FB_PULSE   = 3'h3;
  localparam logic [5:0] SYNC_CODE      = 6'h20;
  localparam logic [2:0] POUT_FREQ_CMD  = 3'h1;
  localparam logic [2:0] POUT_OUT_FREQ  = 3'h2;
  localparam logic [2:0] POUT_SFS_FREQ  = 3'h3;
  localparam logic [2:0] POUT_SPEED     = 3'h4;
  localparam logic [2:0] POUT_PID_FB    = 3'h5;
  localparam logic [2:0] POUT_PID_IN    = 3'h6;
  localparam logic [2:0] POUT_ENC_REP   = 3'h7;

  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_MEAS  = 1;

  typedef struct packed {
    logic [2:0] pid_fb_src;
    logic [2:0] pout_src;
    logic [1:0] pin_func;
    logic [2:0] ref_src;
  } ptio_cfg_t;

  typedef struct packed {
    logic [5:0] code;
    logic [2:0] term;
  } ptio_sync_t;
endpackage : ptio_pkg

/* File: tb/ptio_pulse_src.sv */
`timescale 1ns/1ps
// Far-side pulse source: a generator, an encoder or a leading drive.
// It gives a square wave with a settable half period, so it can run fast or slow.
// When stopped, the line idles low, as an open line with a pull-down would.
module ptio_pulse_src (
  input  wire logic        hclk,
  input  wire logic        run,
  input  wire logic [15:0] half_cyc,
  output logic             pulse_out
);
  logic [15:0] cnt_r;
  logic        level_r = 1'b0;

  // Only magnitude travels on this line; direction stays with the run commands.
  always_ff @(posedge hclk) begin
    if (!run) begin
      cnt_r   <= 16'h0000;
      level_r <= 1'b0;
    end else if (cnt_r >= half_cyc - 16'h0001) begin
      cnt_r   <= 16'h0000;
      level_r <= ~level_r;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  assign pulse_out = level_r;
endmodule : ptio_pulse_src

/* File: tb/pulse_train_io_scaler_bench.sv */
`timescale 1ns/1ps
module pulse_train_io_scaler_bench;
  import ptio_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, src_run, enc_run;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        pin_in, enc_pin, out_pin, fault, irq, ce;
  logic        ref_ok, fb_ok, tgt_ok;
  logic [7:0]  di_in;
  logic [15:0] pct [1:6];
  logic [15:0] out_hz, ref_pct, fb_pct, tgt_pct;
  int          num_errors = 0;
  int          comparisons = 0;

  ptio_scaler #(.GATE_CYCLES(1000), .TICK_CYCLES(50)) ptio_scaler_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pulse_train_in_pin(pin_in),
    .encoder_feedback(enc_pin), .di_in(di_in), .freq_cmd_pct(pct[1]),
    .out_freq_pct(pct[2]), .sfs_freq_pct(pct[3]), .motor_speed_pct(pct[4]),
    .pid_fb_quant_pct(pct[5]), .pid_in_pct(pct[6]), .out_freq_hz(out_hz),
    .freq_ref_pct(ref_pct), .freq_ref_valid(ref_ok), .pid_fb_pct(fb_pct),
    .pid_fb_valid(fb_ok), .pid_tgt_pct(tgt_pct), .pid_tgt_valid(tgt_ok),
    .pulse_setting_fault(fault), .pulse_train_out_pin(out_pin), .irq(irq));
  ptio_pulse_src ptio_pulse_src_i (
    .hclk(hclk), .run(src_run), .half_cyc(16'h0014), .pulse_out(pin_in));
  ptio_pulse_src ptio_pulse_src_enc_i (
    .hclk(hclk), .run(enc_run), .half_cyc(16'h0005), .pulse_out(enc_pin));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  // Address phase is held until hready is seen high, then the data phase likewise.
  task automatic ahb(input logic wr_en, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd_data);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr  <= {24'h000000, ofs};
    hsize  <= 3'h2;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    rd_data = hrdata;
    if (n >= 50) begin
      num_errors++;
      conclude();
    end
    check({31'h0, hresp}, 32'h0, "response");
  endtask : ahb

  task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
    logic [31:0] dummy;
    ahb(1'b1, ofs, wd, dummy);
  endtask : wr

  task automatic rd(input logic [7:0] ofs, output logic [31:0] rdv);
    ahb(1'b0, ofs, 32'h0, rdv);
  endtask : rd

  // Cycles between two rising edges of the output pin; 20000 means fewer than two were seen.
  task automatic period(output int c);
    int  n;
    logic prev;
    n = 0;
    c = 0;
    prev = 1'b1;
    while (n < 2 && c < 20000) begin
      @(negedge hclk);
      c++;
      if (out_pin === 1'b1 && prev === 1'b0) begin
        n++;
        if (n == 1) c = 0;
      end
      prev = out_pin;
    end
  endtask : period

  task automatic t_regs();
    rd(OFS_CFG, d);
    check(d, 32'h0, "cfg reset");
    rd(OFS_PIN_GAIN, d);
    check(d, {16'h0, PIN_GAIN_RST}, "gain reset");
    rd(OFS_POUT_SCALE, d);
    check(d, {16'h0, POUT_SCALE_RST}, "out scale reset");
    wr(OFS_PIN_SCALE, 32'h0000000A);
    rd(OFS_PIN_SCALE, d);
    check(d, 32'h00000032, "scale low clamp");
    wr(OFS_PIN_SCALE, 32'h00009C40);
    rd(OFS_PIN_SCALE, d);
    check(d, 32'h00007D00, "scale high clamp");
    wr(OFS_PIN_BIAS, 32'hFFFFF830);
    rd(OFS_PIN_BIAS, d);
    check(d, 32'hFFFFFC18, "bias clamp");
    wr(OFS_PIN_FILT, 32'h0000012C);
    rd(OFS_PIN_FILT, d);
    check(d, 32'h000000C8, "filter clamp");
    rd(8'h3C, d);
    check(d, 32'h0, "unmapped read");
    $display("test registers done");
  endtask : t_regs

  task automatic t_input();
    int n;
    wr(OFS_PIN_SCALE, 32'h00000032);
    wr(OFS_PIN_GAIN, 32'h000001F4);
    wr(OFS_PIN_BIAS, 32'h00000064);
    wr(OFS_PIN_FILT, 32'h0);
    wr(OFS_SYNC, {23'h0, SYNC_CODE, 3'h0});
    wr(OFS_CFG, {29'h0, REF_SRC_PULSE});
    src_run <= 1'b1;
    repeat (2500) @(posedge hclk);
    rd(OFS_MEAS, d);
    check(d, 32'd25, "edges per gate");
    check({31'h0, ref_ok}, 32'h1, "ref valid");
    check({16'h0, ref_pct}, 32'h0, "ref held without sync");
    di_in <= 8'h01;
    repeat (100) @(posedge hclk);
    check({16'h0, ref_pct}, 25 * 10000 / 50 * 500 / 1000 + 1000, "scaled ref");
    wr(OFS_PIN_FILT, 32'h1);
    wr(OFS_PIN_GAIN, 32'h000003E8);
    n = 0;
    do begin @(negedge hclk); n++; end while (ref_pct === 16'd3500 && n < 3000);
    check({16'h0, ref_pct}, 3500 + (6000 - 3500) / 2, "filter step");
    $display("test pulse input done");
  endtask : t_input

  task automatic t_pid();
    wr(OFS_PIN_FILT, 32'h0);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_CFG, 32'h00000008);
    repeat (4) @(posedge hclk);
    check({31'h0, fault}, 32'h1, "setting fault");
    check({31'h0, fb_ok}, 32'h1, "feedback valid");
    check({31'h0, ref_ok}, 32'h0, "ref not valid");
    check({31'h0, irq}, 32'h1, "fault irq");
    rd(OFS_IRQ_STAT, d);
    check({31'h0, d[IRQ_FAULT]}, 32'h1, "fault status");
    check({31'h0, d[IRQ_MEAS]}, 32'h1, "gate status");
    wr(OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    repeat (2200) @(posedge hclk);
    check({16'h0, fb_pct}, 32'd6000, "feedback value");
    rd(OFS_REF, d);
    check(d, 32'd6000, "filtered ref register");
    wr(OFS_CFG, {21'h0, PID_FB_PULSE, 8'h08});
    repeat (4) @(posedge hclk);
    check({31'h0, fault}, 32'h0, "fault gone");
    wr(OFS_CFG, 32'h00000010);
    repeat (2200) @(posedge hclk);
    check({30'h0, tgt_ok, fb_ok}, 32'h2, "target valid");
    check({16'h0, tgt_pct}, 32'd6000, "target value");
    $display("test pid routing done");
  endtask : t_pid

  task automatic t_output();
    int c;
    int bad;
    logic [3:0] h;
    wr(OFS_CFG, 32'h0);
    wr(OFS_POUT_SCALE, 32'h00007D00);
    repeat (5000) @(posedge hclk);
    check({31'h0, out_pin}, 32'h0, "no source idle");
    for (int k = 1; k <= 6; k++) begin
      for (int j = 1; j <= 6; j++) pct[j] <= (j == k) ? PCT_FULL : 16'h0000;
      wr(OFS_CFG, 32'(k) << 5);
      period(c);
      check(32'(c >= 3905 && c <= 3907), 32'h1, "full scale period");
    end
    out_hz <= 16'd20000;
    wr(OFS_POUT_SCALE, 32'h0);
    wr(OFS_CFG, {24'h0, POUT_OUT_FREQ, 5'h00});
    period(c);
    check(32'(c >= 6249 && c <= 6251), 32'h1, "drive frequency period");
    wr(OFS_POUT_SCALE, 32'h00000064);
    enc_run <= 1'b1;
    wr(OFS_CFG, {24'h0, POUT_ENC_REP, 5'h00});
    bad = 0;
    h = 4'h0;
    for (int i = 0; i < 60; i++) begin
      @(negedge hclk);
      h = {h[2:0], enc_pin};
      if (i > 10 && out_pin !== h[3]) bad++;
    end
    check(32'(bad), 32'h0, "encoder repeat");
    ce <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    h[0] = out_pin;
    bad = 0;
    repeat (30) begin
      @(negedge hclk);
      if (out_pin !== h[0]) bad++;
    end
    check(32'(bad), 32'h0, "frozen by clock enable");
    @(posedge hclk);
    ce <= 1'b1;
    $display("test pulse output done");
  endtask : t_output

  initial begin
    hresetn = 1'b0;
    ce      = 1'b1;
    hsel    = 1'b0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    haddr   = 32'h0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    di_in   = 8'h00;
    out_hz  = 16'h0000;
    src_run = 1'b0;
    enc_run = 1'b0;
    for (int j = 1; j <= 6; j++) pct[j] = 16'h0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    t_input();
    t_pid();
    t_output();
    conclude();
  end
endmodule : pulse_train_io_scaler_bench
